// file: rtl/npr_preset_bank.sv
// oscillator frequency and phase preset register bank with Avalon-MM slave
//
// Behaviour
// - frequency presets 32-bit RW, reset C0000000
// - phase presets 16-bit RW, reset zero
// - interleaved mode ignores channel B presets
// - channel A frequency words at 228/230/238
// - channel A phase words four above
// - channel B preset words at 240/244/248
// - phase left justified, added to accumulator
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
module npr_preset_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    output logic [31:0] chanAFreq,
    output logic [31:0] chanAPhaseWord,
    output logic [31:0] chanBFreq,
    output logic [31:0] chanBPhaseWord,
    output logic interleavedMode
);

    // ----------------------------------------------------------------
    // bus handshake: one wait cycle, answer on the second edge
    // ----------------------------------------------------------------
    logic ackPend_q;
    logic access;
    assign access = avsRead | avsWrite;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackPend_q <= 1'b0;
        end else begin
            ackPend_q <= access & ~ackPend_q;
        end
    end
    assign avsWaitRequest = access & ~ackPend_q;

    logic doWrite;
    assign doWrite = avsWrite & ackPend_q;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wdata,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    // ----------------------------------------------------------------
    // phase word helpers
    // ----------------------------------------------------------------
    // read-back of a phase register: upper half reads zero
    function automatic logic [31:0] padPhase(input logic [15:0] phase);
        return {16'h0000, phase};
    endfunction : padPhase

    // phase preset placed in the upper half of the accumulator word
    function automatic logic [31:0] leftJust(input logic [15:0] phase);
        return {phase, 16'h0000};
    endfunction : leftJust

    // phase registers keep only the two low byte lanes
    function automatic logic [15:0] mergeLow(input logic [15:0] old, input logic [31:0] wdata,
                                             input logic [3:0] be);
        logic [31:0] full;
        full = mergeBytes(padPhase(old), wdata, be);
        return full[15:0];
    endfunction : mergeLow

    // true on the completing edge of a write to one offset
    function automatic logic wrHit(input logic wrEn, input logic [11:0] addr, input logic [11:0] offset);
        return wrEn && (addr == offset);
    endfunction : wrHit

    // ----------------------------------------------------------------
    // preset storage
    // ----------------------------------------------------------------
    logic [31:0] nco_freq_chan_a_preset1_q, nco_freq_chan_a_preset2_q, nco_freq_chan_a_preset3_q, nco_freq_chan_b_preset0_q, nco_freq_chan_b_preset1_q;
    logic [15:0] nco_phase_chan_a_preset1_q, nco_phase_chan_a_preset2_q, nco_phase_chan_a_preset3_q, nco_phase_chan_b_preset0_q;
    logic [1:0] presetSel_q;
    logic mode_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_freq_chan_a_preset1_q <= npr_pkg::FREQ_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::FREQ_A1_OFFSET)) begin
            nco_freq_chan_a_preset1_q <= mergeBytes(nco_freq_chan_a_preset1_q, avsWriteData, avsByteEnable);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_freq_chan_a_preset2_q <= npr_pkg::FREQ_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::FREQ_A2_OFFSET)) begin
            nco_freq_chan_a_preset2_q <= mergeBytes(nco_freq_chan_a_preset2_q, avsWriteData, avsByteEnable);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_freq_chan_a_preset3_q <= npr_pkg::FREQ_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::FREQ_A3_OFFSET)) begin
            nco_freq_chan_a_preset3_q <= mergeBytes(nco_freq_chan_a_preset3_q, avsWriteData, avsByteEnable);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_freq_chan_b_preset0_q <= npr_pkg::FREQ_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::FREQ_B0_OFFSET)) begin
            nco_freq_chan_b_preset0_q <= mergeBytes(nco_freq_chan_b_preset0_q, avsWriteData, avsByteEnable);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_freq_chan_b_preset1_q <= npr_pkg::FREQ_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::FREQ_B1_OFFSET)) begin
            nco_freq_chan_b_preset1_q <= mergeBytes(nco_freq_chan_b_preset1_q, avsWriteData, avsByteEnable);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_phase_chan_a_preset1_q <= npr_pkg::PHASE_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::PHASE_A1_OFFSET)) begin
            nco_phase_chan_a_preset1_q <= mergeLow(nco_phase_chan_a_preset1_q, avsWriteData, avsByteEnable);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_phase_chan_a_preset2_q <= npr_pkg::PHASE_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::PHASE_A2_OFFSET)) begin
            nco_phase_chan_a_preset2_q <= mergeLow(nco_phase_chan_a_preset2_q, avsWriteData, avsByteEnable);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_phase_chan_a_preset3_q <= npr_pkg::PHASE_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::PHASE_A3_OFFSET)) begin
            nco_phase_chan_a_preset3_q <= mergeLow(nco_phase_chan_a_preset3_q, avsWriteData, avsByteEnable);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_phase_chan_b_preset0_q <= npr_pkg::PHASE_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::PHASE_B0_OFFSET)) begin
            nco_phase_chan_b_preset0_q <= mergeLow(nco_phase_chan_b_preset0_q, avsWriteData, avsByteEnable);
        end
    end

    // ----------------------------------------------------------------
    // control registers: preset selection and interleaved mode
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presetSel_q <= npr_pkg::PRESET_SEL_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::PRESET_SEL_OFFSET) && avsByteEnable[0]) begin
            presetSel_q <= avsWriteData[npr_pkg::SEL_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= npr_pkg::MODE_RESET;
        end else if (wrHit(doWrite, avsAddress, npr_pkg::MODE_CTRL_OFFSET) && avsByteEnable[0]) begin
            mode_q <= avsWriteData[npr_pkg::MODE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // read mux, registered; reads change no state
    // ----------------------------------------------------------------
    logic [31:0] readMux;
    always_comb begin
        case (avsAddress)
            npr_pkg::FREQ_A1_OFFSET: begin
                readMux = nco_freq_chan_a_preset1_q;
            end
            npr_pkg::FREQ_A2_OFFSET: begin
                readMux = nco_freq_chan_a_preset2_q;
            end
            npr_pkg::FREQ_A3_OFFSET: begin
                readMux = nco_freq_chan_a_preset3_q;
            end
            npr_pkg::FREQ_B0_OFFSET: begin
                readMux = nco_freq_chan_b_preset0_q;
            end
            npr_pkg::FREQ_B1_OFFSET: begin
                readMux = nco_freq_chan_b_preset1_q;
            end
            npr_pkg::PHASE_A1_OFFSET: begin
                readMux = padPhase(nco_phase_chan_a_preset1_q);
            end
            npr_pkg::PHASE_A2_OFFSET: begin
                readMux = padPhase(nco_phase_chan_a_preset2_q);
            end
            npr_pkg::PHASE_A3_OFFSET: begin
                readMux = padPhase(nco_phase_chan_a_preset3_q);
            end
            npr_pkg::PHASE_B0_OFFSET: begin
                readMux = padPhase(nco_phase_chan_b_preset0_q);
            end
            npr_pkg::PRESET_SEL_OFFSET: begin
                readMux = {30'h0, presetSel_q};
            end
            npr_pkg::MODE_CTRL_OFFSET: begin
                readMux = {31'h0, mode_q};
            end
            default: begin
                readMux = npr_pkg::UNMAPPED_READ;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avsReadData <= 32'h00000000;
        end else if (avsRead && !ackPend_q) begin
            avsReadData <= readMux;
        end
    end

    // ----------------------------------------------------------------
    // preset selection toward the oscillators
    // ----------------------------------------------------------------
    logic [31:0] selAFreq, selBFreq;
    logic [15:0] selAPhase, selBPhase;
    always_comb begin
        case (presetSel_q)
            2'h1: begin
                selAFreq = nco_freq_chan_a_preset1_q;
                selAPhase = nco_phase_chan_a_preset1_q;
                selBFreq = nco_freq_chan_b_preset1_q;
                selBPhase = npr_pkg::PHASE_RESET;
            end
            2'h2: begin
                selAFreq = nco_freq_chan_a_preset2_q;
                selAPhase = nco_phase_chan_a_preset2_q;
                selBFreq = npr_pkg::FREQ_RESET;
                selBPhase = npr_pkg::PHASE_RESET;
            end
            2'h3: begin
                selAFreq = nco_freq_chan_a_preset3_q;
                selAPhase = nco_phase_chan_a_preset3_q;
                selBFreq = npr_pkg::FREQ_RESET;
                selBPhase = npr_pkg::PHASE_RESET;
            end
            default: begin
                // channel A preset 0 lives outside this bank
                selAFreq = npr_pkg::FREQ_RESET;
                selAPhase = npr_pkg::PHASE_RESET;
                selBFreq = nco_freq_chan_b_preset0_q;
                selBPhase = nco_phase_chan_b_preset0_q;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // oscillator outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chanAFreq <= npr_pkg::FREQ_RESET;
            chanAPhaseWord <= 32'h00000000;
        end else begin
            chanAFreq <= selAFreq;
            chanAPhaseWord <= leftJust(selAPhase);
        end
    end

    // interleaved mode: channel B copies the channel A selection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chanBFreq <= npr_pkg::FREQ_RESET;
            chanBPhaseWord <= 32'h00000000;
        end else if (mode_q) begin
            chanBFreq <= selAFreq;
            chanBPhaseWord <= leftJust(selAPhase);
        end else begin
            chanBFreq <= selBFreq;
            chanBPhaseWord <= leftJust(selBPhase);
        end
    end

    assign interleavedMode = mode_q;

endmodule : npr_preset_bank

// file: shared/npr_pkg.sv
// package: offsets, reset values and field layout of the oscillator preset bank
package npr_pkg;
    localparam logic [11:0] FREQ_A1_OFFSET = 12'h228;
    localparam logic [11:0] PHASE_A1_OFFSET = 12'h22C;
    localparam logic [11:0] FREQ_A2_OFFSET = 12'h230;
    localparam logic [11:0] PHASE_A2_OFFSET = 12'h234;
    localparam logic [11:0] FREQ_A3_OFFSET = 12'h238;
    localparam logic [11:0] PHASE_A3_OFFSET = 12'h23C;
    localparam logic [11:0] FREQ_B0_OFFSET = 12'h240;
    localparam logic [11:0] PHASE_B0_OFFSET = 12'h244;
    localparam logic [11:0] FREQ_B1_OFFSET = 12'h248;
    localparam logic [11:0] MODE_CTRL_OFFSET = 12'h260;
    localparam logic [11:0] PRESET_SEL_OFFSET = 12'h264;
    localparam logic [31:0] FREQ_RESET = 32'hC0000000;
    localparam logic [15:0] PHASE_RESET = 16'h0000;
    localparam logic [1:0] PRESET_SEL_RESET = 2'h0;
    localparam logic MODE_RESET = 1'b0;
    localparam int FREQ_MSB = 31;
    localparam int PHASE_MSB = 15;
    localparam int PHASE_LSB_POS = 16;
    localparam int SEL_MSB = 1;
    localparam int MODE_BIT = 0;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage : npr_pkg

// file: bench/npr_preset_bank_checker.sv
// checker: port-level properties of the oscillator preset bank
`timescale 1ns/1ns
module npr_preset_bank_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest,
    input wire logic [31:0] chanAFreq,
    input wire logic [31:0] chanAPhaseWord,
    input wire logic [31:0] chanBFreq,
    input wire logic [31:0] chanBPhaseWord,
    input wire logic interleavedMode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_value_a: assert property ($rose(rst_n) |-> chanAFreq == 32'hC0000000 && chanAPhaseWord == 32'h0)
        else $error("preset outputs not at reset value");
    phase_low_a: assert property (chanAPhaseWord[15:0] == 16'h0 && chanBPhaseWord[15:0] == 16'h0)
        else $error("phase word not left justified");
    mirror_b_a: assert property ($past(interleavedMode) |-> chanBFreq == chanAFreq
        && chanBPhaseWord == chanAPhaseWord)
        else $error("channel b presets not ignored in interleaved mode");
    one_wait_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("more than one wait cycle");
    first_wait_a: assert property ((avsRead || avsWrite) && !$past(avsRead || avsWrite) |-> avsWaitRequest)
        else $error("no wait in first request cycle");
    idle_wait_a: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest)
        else $error("wait request while idle");
    hold_data_a: assert property (!avsRead ##1 !avsRead |-> $stable(avsReadData))
        else $error("read data changed without a read");
    read_stable_a: assert property (avsRead && !avsWaitRequest |=>
        $stable(chanAFreq) && $stable(chanBFreq))
        else $error("read disturbed oscillator outputs");
    cover property (avsWrite && !avsWaitRequest);
    cover property (avsRead && !avsWaitRequest);
    cover property (interleavedMode && chanBFreq != 32'hC0000000);
endmodule : npr_preset_bank_checker
bind npr_preset_bank npr_preset_bank_checker i_npr_preset_bank_checker (.clk(clk), .rst_n(rst_n),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .chanAFreq(chanAFreq), .chanAPhaseWord(chanAPhaseWord), .chanBFreq(chanBFreq),
    .chanBPhaseWord(chanBPhaseWord), .interleavedMode(interleavedMode));

// file: bench/npr_preset_bank_tb_top.sv
// testbench: register access and preset outputs of the oscillator preset bank
`timescale 1ns/1ns
module npr_preset_bank_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] avsAddress = 12'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [3:0] avsByteEnable = 4'hF;
    logic [31:0] avsReadData, chanAFreq, chanAPhaseWord, chanBFreq, chanBPhaseWord;
    logic avsWaitRequest, interleavedMode;
    logic [31:0] mdl [9];
    logic [31:0] expQ [$];
    int err_count = 0;
    int check_count = 0;
    always #25 clk = ~clk;
    npr_preset_bank i_npr_preset_bank (.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .chanAFreq(chanAFreq),
        .chanAPhaseWord(chanAPhaseWord), .chanBFreq(chanBFreq), .chanBPhaseWord(chanBPhaseWord),
        .interleavedMode(interleavedMode));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // request held until wait request is seen low at a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        avsAddress <= a;
        avsWriteData <= d;
        avsByteEnable <= be;
        avsRead <= !wr;
        avsWrite <= wr;
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask : rd
    task automatic wr(input int i, input logic [31:0] d, input logic [3:0] be);
        for (int b = 0; b < 4; b++) if (be[b]) mdl[i][8*b+:8] = d[8*b+:8];
        if (i % 2 == 1) mdl[i][31:16] = 16'h0;
        bus(1'b1, 12'h228 + 12'(4 * i), d, be);
    endtask : wr
    task automatic outs(input int s, input logic m);
        logic [31:0] af, ap, bf, bp;
        af = (s == 0) ? 32'hC0000000 : mdl[2 * s - 2];
        ap = (s == 0) ? 32'h0 : {mdl[2 * s - 1][15:0], 16'h0};
        bf = (s == 0) ? mdl[6] : ((s == 1) ? mdl[8] : 32'hC0000000);
        bp = (s == 0) ? {mdl[7][15:0], 16'h0} : 32'h0;
        bus(1'b1, 12'h264, 32'(s), 4'hF);
        bus(1'b1, 12'h260, {31'h0, m}, 4'hF);
        avsWrite <= 1'b0;
        repeat (3) @(posedge clk);
        chk("chanAFreq", chanAFreq, af);
        chk("chanAPhaseWord", chanAPhaseWord, ap);
        chk("chanBFreq", chanBFreq, m ? af : bf);
        chk("chanBPhaseWord", chanBPhaseWord, m ? ap : bp);
        chk("interleavedMode", {31'h0, interleavedMode}, {31'h0, m});
    endtask : outs
    always @(posedge clk) begin
        if (avsRead === 1'b1 && avsWaitRequest === 1'b0) begin
            chk("avsReadData", avsReadData, expQ.pop_front());
        end
    end
    initial begin
        void'($urandom(32'hB5D7));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            mdl[i] = (i % 2 == 1) ? 32'h0 : 32'hC0000000;
            rd(12'h228 + 12'(4 * i), mdl[i]);
        end
        rd(12'h220, 32'h0);
        bus(1'b1, 12'h24C, 32'hFFFFFFFF, 4'hF);
        rd(12'h24C, 32'h0);
        for (int i = 0; i < 9; i++) wr(i, $urandom(), 4'hF);
        wr(0, $urandom(), 4'h5);
        wr(3, $urandom(), 4'hE);
        for (int i = 0; i < 9; i++) rd(12'h228 + 12'(4 * i), mdl[i]);
        for (int s = 0; s < 4; s++) begin
            outs(s, 1'b0);
            outs(s, 1'b1);
        end
        end_sim();
    end
    initial begin
        #(50 * 4000);
        err_count++;
        end_sim();
    end
endmodule : npr_preset_bank_tb_top
